// >>> hw/pdmw_top.sv
// microphone sample writer: apb registers, capture control, pin routing, memory writes
// assumes a write-channel master port whose sink may stall, and pins muxed with gpio
`timescale 1ns/1ns
module pdmw_top
  import pdmw_pkg::*;
(
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic [11:0]            paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // memory write channel
  output pdmw_pkg::pdmw_dma_t         dma_req,
  output logic                        dma_valid,
  input  wire logic                   dma_ready,
  // pins and their gpio defaults
  input  wire logic [NUM_PINS-1:0]    gpio_out,
  input  wire logic [NUM_PINS-1:0]    gpio_dir,
  input  wire logic [NUM_PINS-1:0]    pin_in,
  output logic      [NUM_PINS-1:0]    pin_out,
  output logic      [NUM_PINS-1:0]    pin_oe
);
  import pdmw_pkg::*;

  function automatic logic psel_on(input logic [31:0] sel);
    psel_on = !sel[PSEL_DISC_BIT];
  endfunction : psel_on

  // register state
  logic [31:0]        sub_start_r, sub_stop_r, pub_began_r, pub_halted_r, pub_full_r;
  logic               ev_began_r, ev_halted_r, ev_full_r;
  logic [2:0]         irq_mask_r;
  logic               enable_r;
  logic [31:0]        clkgen_r;
  logic               mono_r, edge_swap_r, ratio_sel_r, mclk_src_r;
  logic [VOL_W-1:0]   vol_l_r, vol_r_r;
  logic [31:0]        pin_clk_r, pin_din_r;
  logic [31:0]        ptr_r;
  logic [LEN_W-1:0]   len_r;
  logic               pready_r, pslverr_r;
  logic [31:0]        prdata_r;

  // capture state
  pdmw_state_t        state_r;
  logic [31:0]        cur_ptr_r;
  logic [LEN_W-1:0]   cur_len_r;
  logic [LEN_W:0]     done_cnt_r;
  logic [LEN_W-2:0]   word_idx_r;
  logic [15:0]        hold_r;
  logic               half_r;
  logic [31:0]        word_r;
  logic               word_rdy_r;
  pdmw_dma_t          dma_r;
  logic               dma_valid_r;
  logic               mclk_r;
  logic [3:0]         div_r;
  logic [NUM_PINS-1:0] pin_out_r, pin_oe_r, pin_out_nxt, pin_oe_nxt;

  // bus decode
  logic        acc, wr_en, rd_take;
  logic        w_start, w_stop;
  logic [32:0] rd_word;

  assign acc     = psel && penable;
  assign wr_en   = acc && pready_r && pwrite;
  assign rd_take = acc && !pready_r;
  assign w_start = wr_en && (paddr == OFS_START) && pwdata[TASK_BIT];
  assign w_stop  = wr_en && (paddr == OFS_STOP) && pwdata[TASK_BIT];

  function automatic logic [32:0] rd_mux(input logic [11:0] a);
    case (a)
      OFS_START, OFS_STOP:         rd_mux = {1'b0, 32'h0000_0000};
      OFS_SUB_START:               rd_mux = {1'b0, sub_start_r};
      OFS_SUB_STOP:                rd_mux = {1'b0, sub_stop_r};
      OFS_EV_BEGAN:                rd_mux = {1'b0, 31'h0, ev_began_r};
      OFS_EV_HALTED:               rd_mux = {1'b0, 31'h0, ev_halted_r};
      OFS_EV_FULL:                 rd_mux = {1'b0, 31'h0, ev_full_r};
      OFS_PUB_BEGAN:               rd_mux = {1'b0, pub_began_r};
      OFS_PUB_HALTED:              rd_mux = {1'b0, pub_halted_r};
      OFS_PUB_FULL:                rd_mux = {1'b0, pub_full_r};
      OFS_IRQ_MASK, OFS_IRQ_SET,
      OFS_IRQ_CLR:                 rd_mux = {1'b0, 29'h0, irq_mask_r};
      OFS_ENABLE:                  rd_mux = {1'b0, 31'h0, enable_r};
      OFS_CLKGEN:                  rd_mux = {1'b0, clkgen_r};
      OFS_ROUTING:                 rd_mux = {1'b0, 30'h0, edge_swap_r, mono_r};
      OFS_VOL_L:                   rd_mux = {1'b0, 25'h0, vol_l_r};
      OFS_VOL_R:                   rd_mux = {1'b0, 25'h0, vol_r_r};
      OFS_RATIO:                   rd_mux = {1'b0, 31'h0, ratio_sel_r};
      OFS_PIN_CLK:                 rd_mux = {1'b0, pin_clk_r};
      OFS_PIN_DIN:                 rd_mux = {1'b0, pin_din_r};
      OFS_MCLK_SRC:                rd_mux = {1'b0, 31'h0, mclk_src_r};
      OFS_PTR:                     rd_mux = {1'b0, ptr_r};
      OFS_LEN:                     rd_mux = {1'b0, 16'h0000, len_r};
      default:                     rd_mux = {1'b1, 32'h0000_0000};
    endcase
  endfunction : rd_mux

  assign rd_word = rd_mux(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= rd_take;
      pslverr_r <= rd_take && rd_word[32];
      prdata_r  <= (rd_take && !pwrite) ? rd_word[31:0] : 32'h0000_0000;
    end
  end

  // plain configuration registers; pointer writes never touch the latched copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_start_r  <= 32'h0000_0000;
      sub_stop_r   <= 32'h0000_0000;
      pub_began_r  <= 32'h0000_0000;
      pub_halted_r <= 32'h0000_0000;
      pub_full_r   <= 32'h0000_0000;
      irq_mask_r   <= 3'h0;
      enable_r     <= 1'b0;
      clkgen_r     <= RST_CLKGEN;
      mono_r       <= 1'b0;
      edge_swap_r  <= 1'b0;
      ratio_sel_r  <= 1'b0;
      mclk_src_r   <= 1'b0;
      vol_l_r      <= RST_VOL;
      vol_r_r      <= RST_VOL;
      pin_clk_r    <= RST_PSEL;
      pin_din_r    <= RST_PSEL;
      ptr_r        <= 32'h0000_0000;
      len_r        <= 16'h0000;
    end else if (wr_en) begin
      case (paddr)
        OFS_SUB_START:  sub_start_r  <= pwdata & PUBSUB_MASK;
        OFS_SUB_STOP:   sub_stop_r   <= pwdata & PUBSUB_MASK;
        OFS_PUB_BEGAN:  pub_began_r  <= pwdata & PUBSUB_MASK;
        OFS_PUB_HALTED: pub_halted_r <= pwdata & PUBSUB_MASK;
        OFS_PUB_FULL:   pub_full_r   <= pwdata & PUBSUB_MASK;
        OFS_IRQ_MASK:   irq_mask_r   <= pwdata[2:0];
        OFS_IRQ_SET:    irq_mask_r   <= irq_mask_r | pwdata[2:0];
        OFS_IRQ_CLR:    irq_mask_r   <= irq_mask_r & ~pwdata[2:0];
        OFS_ENABLE:     enable_r     <= pwdata[ENABLE_BIT];
        OFS_CLKGEN:     clkgen_r     <= pwdata;
        OFS_ROUTING: begin
          mono_r      <= pwdata[MODE_MONO_BIT];
          edge_swap_r <= pwdata[MODE_EDGE_BIT];
        end
        OFS_VOL_L:      vol_l_r      <= pwdata[VOL_W-1:0];
        OFS_VOL_R:      vol_r_r      <= pwdata[VOL_W-1:0];
        OFS_RATIO:      ratio_sel_r  <= pwdata[RATIO_BIT]; // see RL19
        OFS_PIN_CLK:    pin_clk_r    <= pwdata & PSEL_MASK;
        OFS_PIN_DIN:    pin_din_r    <= pwdata & PSEL_MASK;
        OFS_MCLK_SRC:   mclk_src_r   <= pwdata[MCLK_SRC_BIT];
        OFS_PTR:        ptr_r        <= pwdata;
        OFS_LEN:        len_r        <= pwdata[LEN_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // microphone clock and bit sampling
  logic       running, mclk_flip, fall_ev, rise_ev, din_s;
  logic [NUM_PINS-1:0] pin_s;
  logic       l_stb, r_stb, l_valid, r_valid;
  logic [6:0] ratio;
  logic [15:0] l_smp, r_smp;

  assign running   = enable_r && !state_r[0];
  assign mclk_flip = running && (div_r == MIC_HALF_CYC - 4'h1);
  assign fall_ev   = mclk_flip && mclk_r;
  assign rise_ev   = mclk_flip && !mclk_r;
  assign l_stb     = edge_swap_r ? rise_ev : fall_ev; // see RL18, RL22
  assign r_stb     = edge_swap_r ? fall_ev : rise_ev; // see RL18, RL22
  assign ratio     = ratio_sel_r ? RATIO_80 : RATIO_64; // see RL20
  assign din_s     = psel_on(pin_din_r) && enable_r
                     && pin_s[pin_din_r[PSEL_PIN_MSB:0]]; // see RL14

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_r <= 1'b0;
      div_r  <= 4'h0;
    end else begin
      div_r  <= (!running || mclk_flip) ? 4'h0 : div_r + 4'h1;
      mclk_r <= running && (mclk_flip ? !mclk_r : mclk_r);
    end
  end

  // every pin passes its own two flops before the route selector reads it
  genvar gs;
  generate
    for (gs = 0; gs < NUM_PINS; gs++) begin : g_pin_sync
      pdmw_sync u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pin_in[gs]),
        .sync_r   (pin_s[gs])
      );
    end
  endgenerate

  // the filter needs a few windows to settle after start; early samples are not masked
  // see RL8
  logic [1:0] ch_stb;
  logic [1:0] ch_valid;
  logic [15:0] ch_smp [2];
  assign ch_stb  = {r_stb, l_stb};
  assign l_valid = ch_valid[0];
  assign r_valid = ch_valid[1];
  assign l_smp   = ch_smp[0];
  assign r_smp   = ch_smp[1];

  genvar gc;
  generate
    for (gc = 0; gc < 2; gc++) begin : g_chan
      pdmw_decim u_decim (
        .pclk     (pclk),
        .presetn  (presetn),
        .bit_stb  (ch_stb[gc]),
        .bit_val  (din_s),
        .ratio    (ratio),
        .sample_r (ch_smp[gc]),
        .valid_r  (ch_valid[gc])
      );
    end
  endgenerate

  // word packing, left sample (in mono the earlier one) in the low half; a stereo word waits for both channels
  // of one frame, whichever edge ends its window first, so left and right stay paired
  logic        word_go, got_l_r, got_r_r, st_l, st_r;
  logic [15:0] rhold_r, st_lo, st_hi;
  logic [31:0] word_nxt;
  assign st_l     = l_valid || got_l_r;
  assign st_r     = r_valid || got_r_r;
  assign st_lo    = l_valid ? l_smp : hold_r;
  assign st_hi    = r_valid ? r_smp : rhold_r;
  assign word_go  = mono_r ? (l_valid && half_r) : (st_l && st_r && (l_valid || r_valid));
  assign word_nxt = mono_r ? {l_smp, hold_r} : {st_hi, st_lo}; // see RL3, RL4, RL5

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r     <= 16'h0000;
      rhold_r    <= 16'h0000;
      got_l_r    <= 1'b0;
      got_r_r    <= 1'b0;
      half_r     <= 1'b0;
      word_r     <= 32'h0000_0000;
      word_rdy_r <= 1'b0;
    end else begin
      word_rdy_r <= word_go && state_r[1];
      if (r_valid) begin
        rhold_r <= r_smp;
      end
      if (state_r[0] || word_go) begin
        got_l_r <= 1'b0;
        got_r_r <= 1'b0;
      end else begin
        got_l_r <= got_l_r || l_valid;
        got_r_r <= got_r_r || r_valid;
      end
      if (l_valid && !(mono_r && half_r)) begin
        hold_r <= l_smp;
      end
      if (state_r[0]) begin
        half_r <= 1'b0;
      end else if (mono_r && l_valid) begin
        half_r <= !half_r;
      end
      if (word_go) begin
        word_r <= word_nxt;
      end
    end
  end

  // capture control and memory writes
  logic w_done, buf_full, do_start, drained;
  assign w_done   = dma_valid_r && dma_ready;
  assign buf_full = w_done && (done_cnt_r + 17'h00002 >= {1'b0, cur_len_r}); // see RL6, RL10
  assign do_start = w_start && enable_r && state_r[0];
  assign drained  = state_r[2] && !dma_valid_r; // see RL21

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= PDMW_IDLE;
      cur_ptr_r   <= 32'h0000_0000;
      cur_len_r   <= 16'h0000;
      done_cnt_r  <= 17'h00000;
      word_idx_r  <= 15'h0000;
      dma_r       <= '0;
      dma_valid_r <= 1'b0;
    end else begin
      case (state_r)
        PDMW_IDLE: begin
          if (do_start) begin // see RL13
            state_r    <= PDMW_RUN;
            cur_ptr_r  <= ptr_r; // see RL9
            cur_len_r  <= len_r;
            done_cnt_r <= 17'h00000;
            word_idx_r <= 15'h0000;
          end
        end
        PDMW_RUN: begin
          if (w_stop || !enable_r) begin
            state_r <= PDMW_DRAIN; // see RL13
          end
        end
        PDMW_DRAIN: begin
          if (drained) begin
            state_r <= PDMW_IDLE; // see RL21
          end
        end
        default: state_r <= PDMW_IDLE;
      endcase
      // a word that finds the channel busy is dropped; at audio rates it never does
      if (word_rdy_r && state_r[1] && !dma_valid_r) begin
        dma_valid_r <= 1'b1;
        dma_r.addr  <= cur_ptr_r + {15'h0000, word_idx_r, 2'b00}; // see RL1
        dma_r.data  <= word_r;
        dma_r.strb  <= DMA_STRB_ALL;
      end else if (w_done) begin
        dma_valid_r <= 1'b0;
      end
      if (buf_full) begin
        cur_ptr_r  <= ptr_r; // see RL11, RL23
        cur_len_r  <= len_r;
        done_cnt_r <= 17'h00000;
        word_idx_r <= 15'h0000;
      end else if (w_done) begin
        done_cnt_r <= done_cnt_r + 17'h00002;
        word_idx_r <= word_idx_r + 15'h0001;
      end
    end
  end

  // event flags: hardware set wins over a software write in the same cycle
  logic set_began, set_halted, set_full;
  assign set_began  = do_start || (buf_full && state_r[1]); // see RL11
  assign set_full   = buf_full || drained; // see RL10, RL12
  assign set_halted = drained; // see RL21

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_began_r  <= 1'b0;
      ev_halted_r <= 1'b0;
      ev_full_r   <= 1'b0;
    end else begin
      ev_began_r  <= set_began || ((wr_en && paddr == OFS_EV_BEGAN) ? pwdata[EV_BIT]
                                                                   : ev_began_r);
      ev_halted_r <= set_halted || ((wr_en && paddr == OFS_EV_HALTED) ? pwdata[EV_BIT]
                                                                     : ev_halted_r);
      ev_full_r   <= set_full || ((wr_en && paddr == OFS_EV_FULL) ? pwdata[EV_BIT]
                                                                 : ev_full_r);
    end
  end

  // pin routing: only the selected pins leave gpio control, and only while enabled
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
      logic own_clk, own_din;
      assign own_clk = enable_r && psel_on(pin_clk_r)
                       && (pin_clk_r[PSEL_PIN_MSB:0] == 5'(gp)); // see RL14, RL15
      assign own_din = enable_r && psel_on(pin_din_r)
                       && (pin_din_r[PSEL_PIN_MSB:0] == 5'(gp)); // see RL14, RL15
      assign pin_out_nxt[gp] = own_clk ? mclk_r : (!own_din && gpio_out[gp]);
      assign pin_oe_nxt[gp]  = own_clk || (!own_din && gpio_dir[gp]);
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_r <= '0;
      pin_oe_r  <= '0;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign dma_req   = dma_r;
  assign dma_valid = dma_valid_r;
  assign pin_out   = pin_out_r;
  assign pin_oe    = pin_oe_r;

  // checks
  sequence s_drain_end;
    state_r[2] && !dma_valid_r ##1 state_r[0] && ev_halted_r && ev_full_r;
  endsequence

  property p_start_runs;
    @(posedge pclk) disable iff (!presetn)
      do_start |=> state_r[1] && ev_began_r;
  endproperty
  a_start_runs: assert property (p_start_runs) else $error("start did not begin capture"); // see RL13

  property p_ptr_latch;
    @(posedge pclk) disable iff (!presetn)
      do_start |=> cur_ptr_r == $past(ptr_r) && cur_len_r == $past(len_r);
  endproperty
  a_ptr_latch: assert property (p_ptr_latch) else $error("pointer not latched at start"); // see RL9

  property p_addr;
    @(posedge pclk) disable iff (!presetn)
      $rose(dma_valid_r) |-> dma_r.addr == cur_ptr_r + {15'h0000, word_idx_r, 2'b00};
  endproperty
  a_addr: assert property (p_addr) else $error("write address off the buffer walk"); // see RL1

  property p_stereo;
    @(posedge pclk) disable iff (!presetn)
      (!mono_r && l_valid && got_r_r) |=> word_r == {$past(rhold_r), $past(l_smp)};
  endproperty
  a_stereo: assert property (p_stereo) else $error("stereo word layout wrong"); // see RL4

  property p_mono;
    @(posedge pclk) disable iff (!presetn)
      (mono_r && l_valid && half_r) |=> word_r == {$past(l_smp), $past(hold_r)};
  endproperty
  a_mono: assert property (p_mono) else $error("mono word layout wrong"); // see RL5

  property p_full;
    @(posedge pclk) disable iff (!presetn)
      (w_done && done_cnt_r + 17'h00002 >= {1'b0, cur_len_r}) |=> ev_full_r && done_cnt_r == 0;
  endproperty
  a_full: assert property (p_full) else $error("end flag missing at buffer full"); // see RL10

  property p_next_buf;
    @(posedge pclk) disable iff (!presetn)
      (buf_full && state_r[1]) |=> cur_ptr_r == $past(ptr_r) && ev_began_r;
  endproperty
  a_next_buf: assert property (p_next_buf) else $error("next buffer not taken up"); // see RL11

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
      (state_r[1] && w_stop && !dma_valid_r && !word_rdy_r) |=> s_drain_end;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not end in stopped"); // see RL21

  property p_gpio;
    @(posedge pclk) disable iff (!presetn)
      !enable_r |=> pin_oe_r == $past(gpio_dir) && pin_out_r == $past(gpio_out);
  endproperty
  a_gpio: assert property (p_gpio) else $error("pins not under gpio while off"); // see RL15
endmodule : pdmw_top

// >>> hw/pdmw_pkg.sv
// constants, types and register map of the pulse-density microphone sample writer
// assumes a 100 MHz peripheral clock and a 12-bit byte address on the register bus
// Notes on behaviour
// RL1 - samples go to pointer, advancing word by word
// RL2 - software keeps pointer inside data RAM
// RL3 - samples stored little endian
// RL4 - stereo word: left low half, right high
// RL5 - mono word: earlier left low, later high
// RL6 - length counts 16-bit samples, not words
// RL7 - software sets pointer and length before start
// RL8 - first samples after start may be junk
// RL9 - pointer latched at start, next writable
// RL10 - end raised when length samples written
// RL11 - seamless next buffer, new started raised
// RL12 - end also raised after stop drains
// RL13 - start task runs capture, stop ends it
// RL14 - clock and data routed per pin select
// RL15 - routing only when enabled, else gpio
// RL16 - software preconfigures clock pin low, data in
// RL17 - software gives each pin one owner
// RL18 - left on falling edge, right rising
// RL19 - ratio register selects decimation ratio
// RL20 - ratio is either 64 or 80
// RL21 - stop waits frame, then stopped event; here drain waits only for the pending write
// RL22 - edge swap exchanges sampling edges
// RL23 - no new pointer means reuse latched one
package pdmw_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_START      = 12'h000;
  localparam logic [11:0] OFS_STOP       = 12'h004;
  localparam logic [11:0] OFS_SUB_START  = 12'h080;
  localparam logic [11:0] OFS_SUB_STOP   = 12'h084;
  localparam logic [11:0] OFS_EV_BEGAN   = 12'h100;
  localparam logic [11:0] OFS_EV_HALTED  = 12'h104;
  localparam logic [11:0] OFS_EV_FULL    = 12'h108;
  localparam logic [11:0] OFS_PUB_BEGAN  = 12'h180;
  localparam logic [11:0] OFS_PUB_HALTED = 12'h184;
  localparam logic [11:0] OFS_PUB_FULL   = 12'h188;
  localparam logic [11:0] OFS_IRQ_MASK   = 12'h300;
  localparam logic [11:0] OFS_IRQ_SET    = 12'h304;
  localparam logic [11:0] OFS_IRQ_CLR    = 12'h308;
  localparam logic [11:0] OFS_ENABLE     = 12'h500;
  localparam logic [11:0] OFS_CLKGEN     = 12'h504;
  localparam logic [11:0] OFS_ROUTING    = 12'h508;
  localparam logic [11:0] OFS_VOL_L      = 12'h518;
  localparam logic [11:0] OFS_VOL_R      = 12'h51C;
  localparam logic [11:0] OFS_RATIO      = 12'h520;
  localparam logic [11:0] OFS_PIN_CLK    = 12'h540;
  localparam logic [11:0] OFS_PIN_DIN    = 12'h544;
  localparam logic [11:0] OFS_MCLK_SRC   = 12'h54C;
  localparam logic [11:0] OFS_PTR        = 12'h560;
  localparam logic [11:0] OFS_LEN        = 12'h564;
  // field layouts
  localparam int          TASK_BIT      = 0;
  localparam int          EV_BIT        = 0;
  localparam logic [31:0] PUBSUB_MASK   = 32'h8000_00FF;
  localparam int          IRQ_BEGAN_BIT = 0;
  localparam int          IRQ_HALT_BIT  = 1;
  localparam int          IRQ_FULL_BIT  = 2;
  localparam int          ENABLE_BIT    = 0;
  localparam int          MODE_MONO_BIT = 0;
  localparam int          MODE_EDGE_BIT = 1;
  localparam int          RATIO_BIT     = 0;
  localparam int          MCLK_SRC_BIT  = 0;
  localparam int          PSEL_PIN_MSB  = 4;
  localparam int          PSEL_PORT_BIT = 5;
  localparam int          PSEL_DISC_BIT = 31;
  localparam logic [31:0] PSEL_MASK     = 32'h8000_003F;
  localparam int          VOL_W         = 7;
  localparam int          LEN_W         = 16;
  localparam int          NUM_PINS      = 32;
  // reset values
  localparam logic [31:0]      RST_CLKGEN = 32'h0000_0000;
  localparam logic [31:0]      RST_PSEL   = 32'hFFFF_FFFF;
  localparam logic [VOL_W-1:0] RST_VOL    = 7'h00;
  // decimation ratios
  localparam logic [6:0] RATIO_64 = 7'h40;
  localparam logic [6:0] RATIO_80 = 7'h50;
  // timing
  localparam int         CLK_NS            = 10;
  localparam int         MIC_CLK_PERIOD_NS = 125;
  localparam logic [3:0] MIC_HALF_CYC      = 4'((MIC_CLK_PERIOD_NS / 2) / CLK_NS);
  localparam logic [3:0] DMA_STRB_ALL      = 4'hF;

  typedef enum logic [2:0] {
    PDMW_IDLE  = 3'b001,
    PDMW_RUN   = 3'b010,
    PDMW_DRAIN = 3'b100
  } pdmw_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } pdmw_dma_t;
endpackage : pdmw_pkg

// >>> hw/pdmw_sync.sv
// two-stage synchroniser for one asynchronous level
// assumes the input has no timing relation to pclk
`timescale 1ns/1ns
module pdmw_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // level in and out
  input  wire logic async_in,
  output logic      sync_r
);
  logic meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end
endmodule : pdmw_sync

// >>> hw/pdmw_decim.sv
// one channel of density-to-pcm conversion: counts ones over one ratio window
// assumes bit_stb pulses once per microphone bit; a boxcar, not a real filter
`timescale 1ns/1ns
module pdmw_decim (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // bit stream
  input  wire logic        bit_stb,
  input  wire logic        bit_val,
  input  wire logic [6:0]  ratio,
  // pcm out
  output logic [15:0]      sample_r,
  output logic             valid_r
);
  logic        [6:0] cnt_r;
  logic        [6:0] ones_r;
  logic        [6:0] ones_nxt;
  logic signed [7:0] centred;
  logic              last;

  assign ones_nxt = ones_r + {6'h00, bit_val};
  assign centred  = $signed({1'b0, ones_nxt}) - $signed({2'b00, ratio[6:1]});
  assign last     = (cnt_r == ratio - 7'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r    <= 7'h00;
      ones_r   <= 7'h00;
      sample_r <= 16'h0000;
      valid_r  <= 1'b0;
    end else begin
      valid_r <= bit_stb && last;
      if (bit_stb) begin
        cnt_r  <= last ? 7'h00 : cnt_r + 7'h01;
        ones_r <= last ? 7'h00 : ones_nxt;
        if (last) begin
          sample_r <= {centred, 8'h00};
        end
      end
    end
  end
endmodule : pdmw_decim

// >>> testbench/pdmw_mic_model.sv
// one pulse-density microphone wired as left on the shared data line
// assumes its clock stands low between captures
`timescale 1ns/1ns
module pdmw_mic_model (
  // link
  input  wire logic mic_clk,
  output logic      mic_dat
);
  initial mic_dat = 1'b0;
  // ones while clock is high, zeros while low: left reads full, right empty
  // the short lag keeps data changes off the sampling clock edges
  always @(mic_clk) mic_dat <= #3 mic_clk;
endmodule : pdmw_mic_model

// >>> testbench/pdm_mic_sample_dma_writer_tb_top.sv
// self-checking bench: apb tasks, stalling memory sink, one microphone model
// assumes event flags are cleared by writing zero
`timescale 1ns/1ns
module pdm_mic_sample_dma_writer_tb_top;
  import pdmw_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dma_ready = 0;
  logic        pready, pslverr, dma_valid, mic_dat, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, gpio_out = 32'h100, gpio_dir = 32'h18;
  logic [31:0] prdata, pin_out, pin_oe, rd;
  logic [31:0] mode_tab [4] = '{32'h0, 32'h0, 32'h2, 32'h1};
  logic [31:0] ratio_tab [4] = '{32'h0, 32'h1, 32'h0, 32'h0};
  logic [31:0] word_tab [4] = '{32'hE000_2000, 32'hD800_2800, 32'h2000_E000, 32'h2000_2000};
  pdmw_dma_t   dma_req;
  pdmw_dma_t   wq [$];
  int          fail_count = 0, total_checks = 0;

  pdmw_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_req(dma_req), .dma_valid(dma_valid), .dma_ready(dma_ready),
    .gpio_out(gpio_out), .gpio_dir(gpio_dir), .pin_in({26'h0, mic_dat, 5'h0}),
    .pin_out(pin_out), .pin_oe(pin_oe));
  pdmw_mic_model u_mic (.mic_clk(pin_out[3]), .mic_dat(mic_dat));

  always #5 pclk = ~pclk;
  // sink stalls every other cycle
  always @(posedge pclk) begin
    if (dma_valid && dma_ready) wq.push_back(dma_req);
    dma_ready <= ~dma_ready;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // generous against all four runs in sequence, the mono one the slowest
  initial begin
    #400000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(OFS_PIN_CLK, 1'b0, 32'h0);
    chk(rd, RST_PSEL);
    apb(12'h010, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    chk(pin_oe, gpio_dir);
    chk(pin_out, gpio_out);
    apb(OFS_PIN_CLK, 1'b1, 32'h3);
    apb(OFS_PIN_DIN, 1'b1, 32'h5);
    apb(OFS_LEN, 1'b1, 32'h4);
    apb(OFS_ENABLE, 1'b1, 32'h1);
    repeat (2) @(posedge pclk);
    chk(pin_oe, 32'h18);
    for (int i = 0; i < 4; i++) begin
      apb(OFS_ROUTING, 1'b1, mode_tab[i]);
      apb(OFS_RATIO, 1'b1, ratio_tab[i]);
      apb(OFS_PTR, 1'b1, 32'h2000_0000);
      for (int e = 0; e < 3; e++) apb(OFS_EV_BEGAN + 12'(4 * e), 1'b1, 32'h0);
      wq.delete();
      apb(OFS_START, 1'b1, 32'h1);
      apb(OFS_EV_BEGAN, 1'b0, 32'h0);
      chk(rd, 32'h1);
      apb(OFS_EV_BEGAN, 1'b1, 32'h0);
      apb(OFS_PTR, 1'b1, 32'h2000_0100);
      while (wq.size() < 2) @(posedge pclk);
      apb(OFS_EV_FULL, 1'b0, 32'h0);
      chk(rd, 32'h1);
      apb(OFS_EV_BEGAN, 1'b0, 32'h0);
      chk(rd, 32'h1);
      while (wq.size() < 4) @(posedge pclk);
      apb(OFS_EV_FULL, 1'b1, 32'h0);
      apb(OFS_STOP, 1'b1, 32'h1);
      repeat (3000) if (rd !== 32'h1) apb(OFS_EV_HALTED, 1'b0, 32'h0);
      chk(rd, 32'h1);
      apb(OFS_EV_FULL, 1'b0, 32'h0);
      chk(rd, 32'h1);
      // the first buffer is settling filter output, so only its addresses and strobes are judged
      for (int k = 0; k < 4; k++) begin
        chk(wq[k].addr, 32'h2000_0000 + 32'(k / 2) * 32'h100 + 32'(k % 2) * 4);
        chk({28'h0, wq[k].strb}, 32'hF);
        if (k > 1) chk(wq[k].data, word_tab[i]);
      end
    end
    apb(OFS_ENABLE, 1'b1, 32'h0);
    repeat (2) @(posedge pclk);
    chk(pin_oe, gpio_dir);
    tally_and_finish();
  end
endmodule : pdm_mic_sample_dma_writer_tb_top
